// ### verilog/isr_cfg.svh
// constants for the instrument status reporting block
`ifndef ISR_CFG_SVH
`define ISR_CFG_SVH

`define ISR_WORD_W 16
`define ISR_ZERO_WORD 16'h0000
`define ISR_ONES_WORD 16'hffff

// questionable group bit positions
`define ISR_Q_OVERVOLTAGE_BIT 0
`define ISR_Q_OVERTEMP_BIT 4
`define ISR_Q_REMOTE_BIT 10
`define ISR_Q_DC_ON_BIT 11
`define ISR_Q_POWER_FAIL_BIT 13
`define ISR_Q_IMPL_MASK 16'h7fff

// operation group bit positions
`define ISR_O_VOLT_BIT 8
`define ISR_O_CURR_BIT 9
`define ISR_O_POWER_BIT 10
`define ISR_O_IMPL_MASK 16'h0f00

// status summary byte layout
`define ISR_SB_W 8
`define ISR_SB_ERR_BIT 2
`define ISR_SB_QUES_BIT 3
`define ISR_SB_ESR_BIT 5
`define ISR_SB_OPER_BIT 7
`define ISR_ESR_W 8
`define ISR_ESR_KEEP_MASK 8'h01
`define ISR_ESR_RESET 8'h00

// error codes returned by the error query
`define ISR_ERR_NONE 16'h0000
`define ISR_ERR_SAFETY_OV 16'hfc19

`endif

// ### verilog/isr_pkg.sv
// types shared by the instrument status reporting block
package isr_pkg;

	typedef enum logic [3:0] {
		ISR_QUES_COND,
		ISR_QUES_EVENT,
		ISR_QUES_PLAIN,
		ISR_QUES_EN_RD,
		ISR_QUES_EN_WR,
		ISR_OPER_COND,
		ISR_OPER_EVENT,
		ISR_OPER_PLAIN,
		ISR_OPER_EN_RD,
		ISR_OPER_EN_WR,
		ISR_ERR_QUERY,
		ISR_CLEAR_STATUS,
		ISR_SUMMARY_RD,
		ISR_ESR_RD
	} isr_cmd_t;

endpackage

// ### verilog/isr_group.sv
// one status group: rising-edge event latch, enable mask and summary
`timescale 1ns/1ps
`include "isr_cfg.svh"

module isr_group #(
	parameter int WIDTH = `ISR_WORD_W,
	parameter logic [WIDTH-1:0] IMPL = `ISR_ONES_WORD,
	parameter bit GATE_EVENT = 1'b0
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic [WIDTH-1:0] cond_i,
	input wire logic en_wr_i,
	input wire logic [WIDTH-1:0] en_wdata_i,
	input wire logic evt_clr_i,
	output logic [WIDTH-1:0] evt_o,
	output logic [WIDTH-1:0] en_o,
	output logic summary_o
);

	logic [WIDTH-1:0] prev_r;
	logic [WIDTH-1:0] evt_r;
	logic [WIDTH-1:0] evt_nxt;
	logic [WIDTH-1:0] en_r;
	logic [WIDTH-1:0] rise;
	logic [WIDTH-1:0] gate;

	generate
		if (WIDTH < 1 || IMPL == '0)
		begin : g_bad
			$error("isr_group: empty group");
		end
	endgenerate

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			prev_r <= '0;
		else
			prev_r <= cond_i;
	end

	assign rise = cond_i & ~prev_r;
	assign gate = GATE_EVENT ? en_r : IMPL;

	// a rise in the clearing cycle survives the clear
	always_comb
	begin
		evt_nxt = evt_r;
		if (evt_clr_i)
			evt_nxt = '0;
		evt_nxt = evt_nxt | (rise & gate & IMPL);
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			evt_r <= '0;
		else
			evt_r <= evt_nxt;
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			en_r <= IMPL;
		else if (en_wr_i)
			en_r <= en_wdata_i & IMPL;
	end

	assign evt_o = evt_r;
	assign en_o = en_r;
	assign summary_o = |(evt_r & en_r);

endmodule

// ### verilog/isr_status.sv
// status reporting core: alarm holding, query decode and summary byte
`timescale 1ns/1ps
`include "isr_cfg.svh"

// Overview of operation
// - condition bits follow the live device status inputs directly, except the held alarm bits 0, 4 and 13
// - alarms such as overvoltage appear in condition and event views
// - error query acknowledges alarms; bit clears only once cause is gone
// - safety overvoltage sets power fail bit 13 and overvoltage bit 0
// - safety overvoltage puts unerasable code; only power cycle clears it
// - every group view reads as a 16-bit unsigned value
// - plain questionable query returns event view; explicit forms exist
// - condition view is an unlatched snapshot of current bits
// - questionable bit 10 is remote control, bit 11 is dc on
// - questionable enable is read/write mask toward the summary byte
// - questionable enable resets with all implemented bits set
// - operation enable gates event latching and the operation summary
// - operation enable resets with all implemented bits set
// - plain operation query equals the operation event query
// - operation bit 8 is constant voltage; 1792 passes the three mode bits
// - event views latch only rising condition transitions
// - summary byte bit 3 is questionable, bit 7 is operation
// - clear status empties errors but the safety code, group event views, event register but bit 0
module isr_status #(
	parameter logic [15:0] QUES_IMPL = `ISR_Q_IMPL_MASK,
	parameter logic [15:0] OPER_IMPL = `ISR_O_IMPL_MASK
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic cmd_valid_i,
	input wire isr_pkg::isr_cmd_t cmd_code_i,
	input wire logic [15:0] cmd_wdata_i,
	input wire logic [15:0] ques_live_i,
	input wire logic [15:0] oper_live_i,
	input wire logic overvoltage_alarm_i,
	input wire logic overtemperature_alarm_i,
	input wire logic power_fail_alarm_i,
	input wire logic safety_overvoltage_alarm_i,
	input wire logic remote_active_i,
	input wire logic dc_on_i,
	input wire logic constant_voltage_mode_i,
	input wire logic constant_current_mode_i,
	input wire logic constant_power_mode_i,
	input wire logic err_push_i,
	input wire logic [15:0] err_code_i,
	input wire logic [7:0] esr_set_i,
	output logic rsp_valid_o,
	output logic [15:0] rsp_data_o,
	output logic [7:0] status_summary_byte_o
);

	localparam logic [15:0] QALARM_MASK =
		(16'h0001 << `ISR_Q_OVERVOLTAGE_BIT) |
		(16'h0001 << `ISR_Q_OVERTEMP_BIT) |
		(16'h0001 << `ISR_Q_POWER_FAIL_BIT) |
		(16'h0001 << `ISR_Q_REMOTE_BIT) |
		(16'h0001 << `ISR_Q_DC_ON_BIT);
	localparam logic [15:0] OMODE_MASK =
		(16'h0001 << `ISR_O_VOLT_BIT) |
		(16'h0001 << `ISR_O_CURR_BIT) |
		(16'h0001 << `ISR_O_POWER_BIT);

	generate
		if ((QUES_IMPL & QALARM_MASK) != QALARM_MASK ||
			(OPER_IMPL & OMODE_MASK) != OMODE_MASK)
		begin : g_bad
			$error("isr_status: fixed status bits not implemented");
		end
	endgenerate

	logic cmd_ques_cond;
	logic cmd_ques_evt;
	logic cmd_ques_en_wr;
	logic cmd_oper_cond;
	logic cmd_oper_evt;
	logic cmd_oper_en_wr;
	logic cmd_err_query;
	logic cmd_clear;

	logic ovolt_r;
	logic ovolt_nxt;
	logic otp_r;
	logic otp_nxt;
	logic pfail_r;
	logic pfail_nxt;
	logic safety_ov_r;
	logic err_pend_r;
	logic [15:0] err_code_r;
	logic [7:0] esr_r;
	logic [7:0] esr_nxt;

	logic [15:0] ques_cond;
	logic [15:0] oper_cond;
	logic [15:0] ques_evt;
	logic [15:0] ques_en;
	logic [15:0] oper_evt;
	logic [15:0] oper_en;
	logic ques_sum;
	logic oper_sum;
	logic [7:0] sum_byte;
	logic [15:0] rsp_nxt;
	logic [15:0] err_word;

	assign cmd_ques_cond = cmd_valid_i &&
		cmd_code_i == isr_pkg::ISR_QUES_COND;
	assign cmd_ques_evt = cmd_valid_i &&
		(cmd_code_i == isr_pkg::ISR_QUES_EVENT ||
		cmd_code_i == isr_pkg::ISR_QUES_PLAIN);
	assign cmd_ques_en_wr = cmd_valid_i &&
		cmd_code_i == isr_pkg::ISR_QUES_EN_WR;
	assign cmd_oper_cond = cmd_valid_i &&
		cmd_code_i == isr_pkg::ISR_OPER_COND;
	assign cmd_oper_evt = cmd_valid_i &&
		(cmd_code_i == isr_pkg::ISR_OPER_EVENT ||
		cmd_code_i == isr_pkg::ISR_OPER_PLAIN);
	assign cmd_oper_en_wr = cmd_valid_i &&
		cmd_code_i == isr_pkg::ISR_OPER_EN_WR;
	assign cmd_err_query = cmd_valid_i &&
		cmd_code_i == isr_pkg::ISR_ERR_QUERY;
	assign cmd_clear = cmd_valid_i &&
		cmd_code_i == isr_pkg::ISR_CLEAR_STATUS;

	// alarm bits hold until acknowledged; a live cause always wins the ack
	always_comb
	begin
		ovolt_nxt = ovolt_r;
		otp_nxt = otp_r;
		pfail_nxt = pfail_r;
		if (cmd_err_query)
		begin
			ovolt_nxt = 1'b0;
			otp_nxt = 1'b0;
			pfail_nxt = 1'b0;
		end
		// safety overvoltage pins both bits until the power-on reset clears its latch
		if (overvoltage_alarm_i || safety_overvoltage_alarm_i || safety_ov_r)
			ovolt_nxt = 1'b1;
		if (power_fail_alarm_i || safety_overvoltage_alarm_i || safety_ov_r)
			pfail_nxt = 1'b1;
		if (overtemperature_alarm_i)
			otp_nxt = 1'b1;
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ovolt_r <= 1'b0;
			otp_r <= 1'b0;
			pfail_r <= 1'b0;
		end
		else
		begin
			ovolt_r <= ovolt_nxt;
			otp_r <= otp_nxt;
			pfail_r <= pfail_nxt;
		end
	end

	// no command path clears this; only the power-on reset does
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			safety_ov_r <= 1'b0;
		else if (safety_overvoltage_alarm_i)
			safety_ov_r <= 1'b1;
	end

	// single-entry error store; the full queue lives outside this block
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			err_pend_r <= 1'b0;
		else if (err_push_i)
			err_pend_r <= 1'b1;
		else if (cmd_err_query || cmd_clear)
			err_pend_r <= 1'b0;
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			err_code_r <= `ISR_ERR_NONE;
		else if (err_push_i)
			err_code_r <= err_code_i;
	end

	always_comb
	begin
		esr_nxt = esr_r;
		if (cmd_clear)
			esr_nxt = esr_r & `ISR_ESR_KEEP_MASK;
		esr_nxt = esr_nxt | esr_set_i;
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			esr_r <= `ISR_ESR_RESET;
		else
			esr_r <= esr_nxt;
	end

	// condition views: plain wires, so a read is a live snapshot
	always_comb
	begin
		ques_cond = ques_live_i & ~QALARM_MASK;
		ques_cond[`ISR_Q_OVERVOLTAGE_BIT] = ovolt_r;
		ques_cond[`ISR_Q_OVERTEMP_BIT] = otp_r;
		ques_cond[`ISR_Q_POWER_FAIL_BIT] = pfail_r;
		ques_cond[`ISR_Q_REMOTE_BIT] = remote_active_i;
		ques_cond[`ISR_Q_DC_ON_BIT] = dc_on_i;
		ques_cond = ques_cond & QUES_IMPL;
	end

	always_comb
	begin
		oper_cond = oper_live_i & ~OMODE_MASK;
		oper_cond[`ISR_O_VOLT_BIT] = constant_voltage_mode_i;
		oper_cond[`ISR_O_CURR_BIT] = constant_current_mode_i;
		oper_cond[`ISR_O_POWER_BIT] = constant_power_mode_i;
		oper_cond = oper_cond & OPER_IMPL;
	end

	// questionable mask only filters the summary, events latch regardless
	isr_group #(
		.WIDTH(`ISR_WORD_W),
		.IMPL(QUES_IMPL),
		.GATE_EVENT(1'b0)
	) u_ques (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.cond_i(ques_cond),
		.en_wr_i(cmd_ques_en_wr),
		.en_wdata_i(cmd_wdata_i),
		.evt_clr_i(cmd_ques_evt || cmd_clear),
		.evt_o(ques_evt),
		.en_o(ques_en),
		.summary_o(ques_sum)
	);

	isr_group #(
		.WIDTH(`ISR_WORD_W),
		.IMPL(OPER_IMPL),
		.GATE_EVENT(1'b1)
	) u_oper (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.cond_i(oper_cond),
		.en_wr_i(cmd_oper_en_wr),
		.en_wdata_i(cmd_wdata_i),
		.evt_clr_i(cmd_oper_evt || cmd_clear),
		.evt_o(oper_evt),
		.en_o(oper_en),
		.summary_o(oper_sum)
	);

	always_comb
	begin
		sum_byte = '0;
		sum_byte[`ISR_SB_ERR_BIT] = err_pend_r | safety_ov_r;
		sum_byte[`ISR_SB_QUES_BIT] = ques_sum;
		sum_byte[`ISR_SB_ESR_BIT] = |esr_r;
		sum_byte[`ISR_SB_OPER_BIT] = oper_sum;
	end

	always_comb
	begin
		if (safety_ov_r)
			err_word = `ISR_ERR_SAFETY_OV;
		else if (err_pend_r)
			err_word = err_code_r;
		else
			err_word = `ISR_ERR_NONE;
	end

	always_comb
	begin
		rsp_nxt = `ISR_ZERO_WORD;
		unique case (cmd_code_i)
			isr_pkg::ISR_QUES_COND: rsp_nxt = ques_cond;
			isr_pkg::ISR_QUES_EVENT: rsp_nxt = ques_evt;
			isr_pkg::ISR_QUES_PLAIN: rsp_nxt = ques_evt;
			isr_pkg::ISR_QUES_EN_RD: rsp_nxt = ques_en;
			isr_pkg::ISR_QUES_EN_WR: rsp_nxt = `ISR_ZERO_WORD;
			isr_pkg::ISR_OPER_COND: rsp_nxt = oper_cond;
			isr_pkg::ISR_OPER_EVENT: rsp_nxt = oper_evt;
			isr_pkg::ISR_OPER_PLAIN: rsp_nxt = oper_evt;
			isr_pkg::ISR_OPER_EN_RD: rsp_nxt = oper_en;
			isr_pkg::ISR_OPER_EN_WR: rsp_nxt = `ISR_ZERO_WORD;
			isr_pkg::ISR_ERR_QUERY: rsp_nxt = err_word;
			isr_pkg::ISR_CLEAR_STATUS: rsp_nxt = `ISR_ZERO_WORD;
			isr_pkg::ISR_SUMMARY_RD: rsp_nxt = {8'h00, sum_byte};
			isr_pkg::ISR_ESR_RD: rsp_nxt = {8'h00, esr_r};
			default: rsp_nxt = `ISR_ZERO_WORD;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rsp_valid_o <= 1'b0;
		else
			rsp_valid_o <= cmd_valid_i;
	end

	// the 16-bit word is the whole answer; ascii formatting is upstream
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rsp_data_o <= `ISR_ZERO_WORD;
		else if (cmd_valid_i)
			rsp_data_o <= rsp_nxt;
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			status_summary_byte_o <= '0;
		else
			status_summary_byte_o <= sum_byte;
	end

	a_rsp_follows_cmd: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		cmd_valid_i |=> rsp_valid_o ##1 (rsp_valid_o == $past(cmd_valid_i))
	) else $error("answer not one cycle after command");

	a_ques_plain_event: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		cmd_valid_i && cmd_code_i == isr_pkg::ISR_QUES_PLAIN
		|=> rsp_valid_o && rsp_data_o == $past(ques_evt)
	) else $error("plain questionable query is not the event view");

	a_oper_plain_event: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		cmd_valid_i && cmd_code_i == isr_pkg::ISR_OPER_PLAIN
		|=> rsp_data_o == $past(oper_evt)
	) else $error("plain operation query is not the event view");

	a_cond_snapshot: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		cmd_valid_i && cmd_code_i == isr_pkg::ISR_OPER_COND
		|=> rsp_data_o == $past(oper_cond) &&
			rsp_data_o[`ISR_O_VOLT_BIT] == $past(constant_voltage_mode_i)
	) else $error("condition read is not the live state");

	// the condition bit rises one edge after the cause, the event one later
	a_alarm_held: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		overvoltage_alarm_i && !ovolt_r
		|=> ques_cond[`ISR_Q_OVERVOLTAGE_BIT]
			##1 ques_evt[`ISR_Q_OVERVOLTAGE_BIT]
	) else $error("overvoltage not flagged");

	a_ack_clears_alarm: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		cmd_err_query && !overvoltage_alarm_i &&
		!safety_overvoltage_alarm_i && !safety_ov_r |=> !ovolt_r
	) else $error("acknowledged alarm not cleared");

	a_ack_keeps_live: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		cmd_err_query && power_fail_alarm_i |=> pfail_r
	) else $error("alarm with live cause was cleared");

	a_safety_both_bits: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		safety_overvoltage_alarm_i |=> ovolt_r && pfail_r && safety_ov_r
			##1 safety_ov_r && ovolt_r && pfail_r
	) else $error("safety overvoltage bits not set together");

	a_safety_unerasable: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		safety_ov_r && cmd_err_query |=> safety_ov_r &&
			rsp_data_o == `ISR_ERR_SAFETY_OV
	) else $error("safety overvoltage code lost");

	a_oper_gate_event: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		1'b1 |=> ((oper_evt & ~$past(oper_evt)) & ~$past(oper_en)) == '0
	) else $error("masked operation bit latched");

	a_en_write: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		cmd_oper_en_wr |=> oper_en == ($past(cmd_wdata_i) & OPER_IMPL)
	) else $error("operation enable write lost");

	a_summary_bits: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		1'b1 |=> status_summary_byte_o[`ISR_SB_QUES_BIT] ==
			$past(|(ques_evt & ques_en)) &&
			status_summary_byte_o[`ISR_SB_OPER_BIT] ==
			$past(|(oper_evt & oper_en))
	) else $error("summary byte disagrees with groups");

	a_clear_keeps_bit0: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		cmd_clear && esr_set_i == '0 |=>
			esr_r == ($past(esr_r) & `ISR_ESR_KEEP_MASK)
	) else $error("clear status handled event register wrongly");

	// only a rise seen in the clearing cycle may survive the read
	a_event_read_clear: assert property (
		@(posedge mclk_i) disable iff (!rstn_i)
		cmd_ques_evt |=> (ques_evt & ~($past(ques_cond) &
			~$past(ques_cond, 2))) == '0
	) else $error("event view not cleared by read");

endmodule

// ### verification/isr_host.sv
// remote host model issuing status queries and capturing answers
`timescale 1ns/1ps

module isr_host (
	input wire logic mclk_i,
	input wire logic rsp_valid_i,
	input wire logic [15:0] rsp_data_i,
	output logic cmd_valid_o,
	output isr_pkg::isr_cmd_t cmd_code_o,
	output logic [15:0] cmd_wdata_o
);
	initial
	begin
		cmd_valid_o = 1'b0;
		cmd_code_o = isr_pkg::ISR_SUMMARY_RD;
		cmd_wdata_o = 16'h0000;
	end

	// one command per call; the caller polls status before acknowledging
	// write data is inverted once the command is taken, so stale use shows
	task automatic query(input isr_pkg::isr_cmd_t c, input logic [15:0] w,
		output logic [15:0] d, output logic v);
		@(negedge mclk_i);
		cmd_valid_o <= 1'b1;
		cmd_code_o <= c;
		cmd_wdata_o <= w;
		@(negedge mclk_i);
		cmd_valid_o <= 1'b0;
		cmd_wdata_o <= ~w;
		d = rsp_data_i;
		v = rsp_valid_i;
	endtask
endmodule

// ### verification/tb.sv
// self-checking bench for the status reporting core
`timescale 1ns/1ps

module tb;
	typedef struct {
		isr_pkg::isr_cmd_t code;
		logic [15:0] wd;
		logic [15:0] exp;
	} isr_row_t;

	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic cmd_valid;
	isr_pkg::isr_cmd_t cmd_code;
	logic [15:0] cmd_wdata;
	logic [15:0] ques_live = 16'h0002;
	logic [15:0] oper_live = 16'h0800;
	logic ov = 1'b0;
	logic ot = 1'b0;
	logic sov = 1'b0;
	logic remote = 1'b1;
	logic dc_on = 1'b1;
	logic volt_mode = 1'b1;
	logic curr_mode = 1'b0;
	logic pwr_mode = 1'b0;
	logic pwr_fail = 1'b0;
	logic err_push = 1'b0;
	logic [15:0] err_code = 16'h0000;
	logic [7:0] esr_set = 8'h00;
	logic rsp_valid;
	logic [15:0] rsp_data;
	logic [7:0] sum_byte;
	int err_total = 0;
	int checked = 0;
	int cycles = 0;
	isr_row_t rows [10];

	always #4 mclk = ~mclk;

	isr_status i_isr_status (
		.mclk_i(mclk), .rstn_i(rstn), .cmd_valid_i(cmd_valid),
		.cmd_code_i(cmd_code), .cmd_wdata_i(cmd_wdata),
		.ques_live_i(ques_live), .oper_live_i(oper_live),
		.overvoltage_alarm_i(ov), .overtemperature_alarm_i(ot),
		.power_fail_alarm_i(pwr_fail), .safety_overvoltage_alarm_i(sov),
		.remote_active_i(remote), .dc_on_i(dc_on),
		.constant_voltage_mode_i(volt_mode),
		.constant_current_mode_i(curr_mode),
		.constant_power_mode_i(pwr_mode), .err_push_i(err_push),
		.err_code_i(err_code), .esr_set_i(esr_set),
		.rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
		.status_summary_byte_o(sum_byte)
	);

	isr_host i_isr_host (
		.mclk_i(mclk), .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data),
		.cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
		.cmd_wdata_o(cmd_wdata)
	);

	task automatic close_out;
		if (err_total == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			err_total++;
		end
	endtask

	// every answer is a one-cycle strobe with a 16-bit word
	task automatic ask(input isr_pkg::isr_cmd_t c, input logic [15:0] w,
		input logic [15:0] exp);
		logic [15:0] d;
		logic v;
		i_isr_host.query(c, w, d, v);
		chk({15'h0000, v}, 16'h0001);
		chk(d, exp);
	endtask

	// events latch on one edge and the summary byte follows on the next
	task automatic sum_byte_is(input logic [7:0] m,
		input logic [7:0] exp);
		repeat (2) @(negedge mclk);
		chk({8'h00, sum_byte & m}, {8'h00, exp});
	endtask

	task automatic do_reset;
		@(negedge mclk);
		rstn = 1'b0;
		repeat (2) @(negedge mclk);
		chk({7'h00, rsp_valid, sum_byte}, 16'h0000);
		rstn = 1'b1;
	endtask

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			err_total++;
			close_out();
		end
	end

	initial
	begin
		rows[0] = '{isr_pkg::ISR_QUES_COND, 16'h0000, 16'h0c02};
		rows[1] = '{isr_pkg::ISR_QUES_PLAIN, 16'h0000, 16'h0c02};
		rows[2] = '{isr_pkg::ISR_QUES_EVENT, 16'h0000, 16'h0000};
		rows[3] = '{isr_pkg::ISR_OPER_COND, 16'h0000, 16'h0900};
		rows[4] = '{isr_pkg::ISR_OPER_PLAIN, 16'h0000, 16'h0900};
		rows[5] = '{isr_pkg::ISR_OPER_EVENT, 16'h0000, 16'h0000};
		rows[6] = '{isr_pkg::ISR_QUES_EN_RD, 16'h0000, 16'h7fff};
		rows[7] = '{isr_pkg::ISR_OPER_EN_RD, 16'h0000, 16'h0f00};
		rows[8] = '{isr_pkg::ISR_OPER_EN_WR, 16'h0700, 16'h0000};
		rows[9] = '{isr_pkg::ISR_QUES_EN_WR, 16'h0c00, 16'h0000};
		repeat (2) @(negedge mclk);
		rstn = 1'b1;
		sum_byte_is(8'hff, 8'h88);
		foreach (rows[i])
			ask(rows[i].code, rows[i].wd, rows[i].exp);
		ask(isr_pkg::ISR_OPER_EN_RD, 16'h0000, 16'h0700);
		ask(isr_pkg::ISR_QUES_EN_RD, 16'h0000, 16'h0c00);
		sum_byte_is(8'h88, 8'h00);
		// masked-out bit 11 must not latch, current and power bits must
		oper_live = 16'h0000;
		repeat (2) @(negedge mclk);
		oper_live = 16'h0800;
		curr_mode = 1'b1;
		pwr_mode = 1'b1;
		sum_byte_is(8'h80, 8'h80);
		ask(isr_pkg::ISR_OPER_COND, 16'h0000, 16'h0f00);
		ask(isr_pkg::ISR_OPER_EVENT, 16'h0000, 16'h0600);
		// alarm stays in the live view after its cause is gone
		ov = 1'b1;
		repeat (2) @(negedge mclk);
		ov = 1'b0;
		sum_byte_is(8'h08, 8'h00);
		ask(isr_pkg::ISR_QUES_COND, 16'h0000, 16'h0c03);
		ask(isr_pkg::ISR_QUES_EVENT, 16'h0000, 16'h0001);
		ask(isr_pkg::ISR_QUES_COND, 16'h0000, 16'h0c03);
		ask(isr_pkg::ISR_ERR_QUERY, 16'h0000, 16'h0000);
		ask(isr_pkg::ISR_QUES_COND, 16'h0000, 16'h0c02);
		ot = 1'b1;
		pwr_fail = 1'b1;
		ask(isr_pkg::ISR_ERR_QUERY, 16'h0000, 16'h0000);
		ask(isr_pkg::ISR_QUES_COND, 16'h0000, 16'h2c12);
		ot = 1'b0;
		pwr_fail = 1'b0;
		ask(isr_pkg::ISR_ERR_QUERY, 16'h0000, 16'h0000);
		ask(isr_pkg::ISR_QUES_COND, 16'h0000, 16'h0c02);
		// queued error and event bits, then clear status keeps esr bit 0
		@(negedge mclk);
		err_push = 1'b1;
		err_code = 16'h0123;
		esr_set = 8'h03;
		@(negedge mclk);
		err_push = 1'b0;
		esr_set = 8'h00;
		sum_byte_is(8'h24, 8'h24);
		ask(isr_pkg::ISR_SUMMARY_RD, 16'h0000, 16'h0024);
		ask(isr_pkg::ISR_CLEAR_STATUS, 16'h0000, 16'h0000);
		sum_byte_is(8'h04, 8'h00);
		ask(isr_pkg::ISR_ESR_RD, 16'h0000, 16'h0001);
		ask(isr_pkg::ISR_ERR_QUERY, 16'h0000, 16'h0000);
		// safety overvoltage: one-cycle cause, survives ack and clear
		@(negedge mclk);
		sov = 1'b1;
		@(negedge mclk);
		sov = 1'b0;
		ask(isr_pkg::ISR_QUES_COND, 16'h0000, 16'h2c03);
		ask(isr_pkg::ISR_ERR_QUERY, 16'h0000, 16'hfc19);
		ask(isr_pkg::ISR_CLEAR_STATUS, 16'h0000, 16'h0000);
		ask(isr_pkg::ISR_ERR_QUERY, 16'h0000, 16'hfc19);
		ask(isr_pkg::ISR_QUES_COND, 16'h0000, 16'h2c03);
		// only a power cycle removes it and restores the masks
		do_reset();
		ask(isr_pkg::ISR_QUES_COND, 16'h0000, 16'h0c02);
		ask(isr_pkg::ISR_ERR_QUERY, 16'h0000, 16'h0000);
		ask(isr_pkg::ISR_QUES_EN_RD, 16'h0000, 16'h7fff);
		ask(isr_pkg::ISR_OPER_EN_RD, 16'h0000, 16'h0f00);
		close_out();
	end
endmodule
